/* src/dhi_host_if.v */
`timescale 1ns/1ps
`default_nettype none
`include "dhi_map.vh"
module dhi_host_if (
  input wire clock_in, // System clock, 40 MHz
  input wire rst_in, // Async reset, high
  input wire iface_strap_hi_in, // Interface strap, high bit
  input wire iface_strap_lo_in, // Interface strap, low bit
  input wire power_on_init_n_in, // Chip init, low active
  input wire cs_n_in, // Chip select, low active
  input wire dc_in, // Data/command selector or address bit
  input wire e_rd_n_in, // Enable or read strobe
  input wire rw_wr_n_in, // Direction or write strobe
  input wire [7:0] host_data_bus_in, // Data lines from host
  output reg [7:0] host_data_bus_out, // Data lines to host
  output reg host_data_bus_oe_out, // High while driving lines 7..0
  input wire [7:0] rd_byte_in, // Read-back byte from core
  output reg [7:0] rx_byte_out, // Received byte
  output reg rx_is_data_out, // 1 display data, 0 command
  output reg rx_valid_out, // Received byte valid
  input wire rx_ready_in, // Core accepts byte
  output reg rd_req_out, // Pulse: host started a read
  output reg [1:0] mode_out, // Active link mode
  output reg init_busy_out // Chip initialisation in progress
);
  localparam ST_ADDR = 2'h0;
  localparam ST_CTRL = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_IDLE = 2'h3;
  localparam [6:0] ADDR_BASE = `DHI_ADDR_BASE;

  // Strap decode, read by the link decode process and by is_par
  function [1:0] strap_mode;
    input hi;
    input lo;
    begin
      strap_mode = {hi, lo}; // see [RULE1]
    end
  endfunction

  wire [1:0] mode = strap_mode(iface_strap_hi_in, iface_strap_lo_in);
  wire sel = !cs_n_in && power_on_init_n_in; // see [RULE4]
  wire is_par = mode[0];

  reg [1:0] mode_q;
  reg e_q;
  reg rd_q;
  reg wr_q;
  reg sck_q;
  reg sda_q;
  reg sel_q;
  reg [7:0] shift;
  reg [3:0] bitcnt;
  reg [1:0] i2c_st;
  reg i2c_co;
  reg i2c_ack;
  reg [8:0] f_wdata;
  reg f_wvalid;
  wire f_wready;
  wire [8:0] f_rdata;
  wire f_rvalid;

  // Staging FIFO between link and core
  dhi_fifo #(.WIDTH(`DHI_FIFO_W), .DEPTH(`DHI_FIFO_D), .AW(`DHI_FIFO_AW)) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clr_in(!power_on_init_n_in),
    .wr_data_in(f_wdata),
    .wr_valid_in(f_wvalid),
    .wr_ready_out(f_wready),
    .rd_data_out(f_rdata),
    .rd_valid_out(f_rvalid),
    .rd_ready_in(rx_valid_out && rx_ready_in)
  );

  // Output register stage toward the core
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_byte_out <= 8'h00;
      rx_is_data_out <= 1'b0;
      rx_valid_out <= 1'b0;
      mode_out <= 2'h0;
      init_busy_out <= 1'b1;
    end else begin
      rx_byte_out <= f_rdata[7:0];
      rx_is_data_out <= f_rdata[`DHI_BIT_DC];
      rx_valid_out <= f_rvalid && !(rx_valid_out && rx_ready_in);
      mode_out <= mode_q;
      init_busy_out <= !power_on_init_n_in; // see [RULE2]
    end
  end

  // Link decode: strobes, serial shifters, two-wire framing
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= 2'h0;
      e_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      sck_q <= 1'b0;
      sda_q <= 1'b1;
      sel_q <= 1'b0;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      i2c_st <= ST_IDLE;
      i2c_co <= 1'b0;
      i2c_ack <= 1'b0;
      f_wdata <= 9'h000;
      f_wvalid <= 1'b0;
      rd_req_out <= 1'b0;
      host_data_bus_out <= 8'h00;
      host_data_bus_oe_out <= 1'b0;
    end else if (!power_on_init_n_in) begin
      // Chip init: clear link state, latch straps
      mode_q <= mode; // see [RULE2]
      e_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      sel_q <= 1'b0;
      bitcnt <= 4'h0;
      i2c_st <= ST_IDLE;
      f_wvalid <= 1'b0;
      rd_req_out <= 1'b0;
      host_data_bus_oe_out <= 1'b0;
    end else begin
      mode_q <= mode;
      f_wvalid <= 1'b0;
      rd_req_out <= 1'b0;
      sel_q <= sel;
      // Strobe histories held inactive outside chip select; serial line histories sck_q, sda_q are not gated
      e_q <= sel && e_rd_n_in;
      rd_q <= sel && !e_rd_n_in;
      wr_q <= sel && !rw_wr_n_in;
      sck_q <= host_data_bus_in[0];
      sda_q <= host_data_bus_in[1];
      host_data_bus_oe_out <= 1'b0;
      case (mode)
        `DHI_MODE_E_STROBE: begin
          if (sel && e_rd_n_in && rw_wr_n_in) begin // see [RULE8] [RULE9]
            host_data_bus_out <= rd_byte_in;
            host_data_bus_oe_out <= 1'b1;
            if (!e_q) rd_req_out <= 1'b1;
          end
          if (e_q && !e_rd_n_in && !rw_wr_n_in) begin // see [RULE15]
            f_wdata <= {dc_in, host_data_bus_in}; // see [RULE5]
            f_wvalid <= f_wready;
          end
        end
        `DHI_MODE_RW_STROBE: begin
          if (sel && !e_rd_n_in) begin // see [RULE10]
            host_data_bus_out <= rd_byte_in;
            host_data_bus_oe_out <= 1'b1;
            if (!rd_q) rd_req_out <= 1'b1;
          end
          if (wr_q && rw_wr_n_in) begin // see [RULE11] [RULE15]
            f_wdata <= {dc_in, host_data_bus_in}; // see [RULE5]
            f_wvalid <= f_wready;
          end
        end
        `DHI_MODE_SPI: begin
          if (!sel) begin
            bitcnt <= 4'h0;
          end else if (!sck_q && host_data_bus_in[0]) begin // see [RULE13]
            shift <= {shift[6:0], host_data_bus_in[1]};
            if (bitcnt == 4'h7) begin
              bitcnt <= 4'h0;
              f_wdata <= {dc_in, shift[6:0], host_data_bus_in[1]}; // see [RULE6]
              f_wvalid <= f_wready;
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        default: begin
          // Two-wire: line 0 clock, line 1 data in, line 2 data out
          if (sck_q && host_data_bus_in[0] && sda_q && !host_data_bus_in[1]) begin
            i2c_st <= ST_ADDR;
            bitcnt <= 4'h0;
          end else if (sck_q && host_data_bus_in[0] && !sda_q && host_data_bus_in[1]) begin
            i2c_st <= ST_IDLE;
          end else if (i2c_st != ST_IDLE && !sck_q && host_data_bus_in[0]) begin
            if (bitcnt < 4'h8) begin
              shift <= {shift[6:0], host_data_bus_in[1]};
            end
            bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
          end else if (i2c_st != ST_IDLE && sck_q && !host_data_bus_in[0]) begin
            if (bitcnt == 4'h8) begin
              i2c_ack <= 1'b1;
              case (i2c_st)
                ST_ADDR: begin
                  if (shift[7:1] == {ADDR_BASE[6:1], dc_in} && !shift[0]) begin // see [RULE7]
                    i2c_st <= ST_CTRL;
                  end else begin
                    i2c_st <= ST_IDLE;
                    i2c_ack <= 1'b0;
                  end
                end
                ST_CTRL: begin
                  i2c_co <= shift[7];
                  i2c_st <= ST_DATA;
                  f_wdata[`DHI_BIT_DC] <= shift[6];
                end
                ST_DATA: begin
                  f_wdata[7:0] <= shift;
                  f_wvalid <= f_wready;
                  if (i2c_co) i2c_st <= ST_CTRL;
                end
                default: i2c_st <= ST_IDLE;
              endcase
            end else if (bitcnt == 4'h0) begin
              i2c_ack <= 1'b0;
            end
          end
          if (i2c_ack) begin
            host_data_bus_out <= 8'h00;
            host_data_bus_oe_out <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // dhi_host_if
`default_nettype wire

/* src/dhi_map.vh */
// Contract
// [RULE1] Straps pick two-wire, four-wire, strobe or split-strobe link
// [RULE2] Low init input resets controller and driver logic
// [RULE3] Host keeps init input high in normal use
// [RULE4] Bus activity ignored unless chip select low; the two-wire link never reads chip select
// [RULE5] Parallel byte: selector high data, low command
// [RULE6] Four-wire bits: selector high data, low command
// [RULE7] Two-wire mode: selector is target address bit zero
// [RULE8] Enable-strobe mode: cycle while enable high, select low
// [RULE9] Enable-strobe mode: direction high read, low write
// [RULE10] Split-strobe mode: read while read strobe, select low
// [RULE11] Split-strobe mode: write while write strobe, select low
// [RULE12] Serial modes: host grounds both strobe inputs
// [RULE13] Four-wire: line 1 data in, line 0 clock
// [RULE14] Two-wire: host joins lines 2 and 1 externally
// [RULE15] Parallel write captures byte at strobe trailing edge
`ifndef DHI_MAP_VH
`define DHI_MAP_VH
`define DHI_MODE_I2C 2'h2
`define DHI_MODE_SPI 2'h0
`define DHI_MODE_E_STROBE 2'h1
`define DHI_MODE_RW_STROBE 2'h3
`define DHI_ADDR_BASE 7'h3C
`define DHI_BYTE_W 8
`define DHI_FIFO_W 9
`define DHI_FIFO_D 8
`define DHI_FIFO_AW 3
`define DHI_BIT_DC 8
`endif

/* src/dhi_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module dhi_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock_in, // System clock
  input wire rst_in, // Async reset, high
  input wire clr_in, // Synchronous flush
  input wire [WIDTH-1:0] wr_data_in, // Write word
  input wire wr_valid_in, // Write request
  output wire wr_ready_out, // Room available
  output wire [WIDTH-1:0] rd_data_out, // Head word
  output wire rd_valid_out, // Head valid
  input wire rd_ready_in // Drain accept
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = wr_valid_in && wr_ready_out;
  wire pop = rd_valid_out && rd_ready_in;
  assign wr_ready_out = (count != DEPTH[AW:0]);
  assign rd_valid_out = (count != {(AW+1){1'b0}});
  assign rd_data_out = mem[rd_ptr];
  // Storage write
  always @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
  // Pointers and occupancy
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (clr_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule // dhi_fifo
`default_nettype wire

/* bench/dhi_host_if_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dhi_host_if_asserts (
  input wire logic clock_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic iface_strap_hi_in, // Strap
  input wire logic iface_strap_lo_in, // Strap
  input wire logic power_on_init_n_in, // Init
  input wire logic cs_n_in, // Select
  input wire logic e_rd_n_in, // Strobe
  input wire logic rw_wr_n_in, // Strobe
  input wire logic rx_valid_out, // Valid
  input wire logic rd_req_out, // Read
  input wire logic [1:0] mode_out, // Mode
  input wire logic init_busy_out // Busy
);
  logic [1:0] st;
  logic p3;
  logic p1;
  // Straps and selected split or enable mode
  assign st = {iface_strap_hi_in, iface_strap_lo_in};
  assign p3 = mode_out == 2'h3 && !cs_n_in;
  assign p1 = mode_out == 2'h1 && !cs_n_in;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  property p_mode; ($stable(st) && power_on_init_n_in) [*3] |-> mode_out == st; endproperty
  a_mode: assert property (p_mode) else $error("mode off straps");
  property p_init; !power_on_init_n_in [*3] |-> init_busy_out && !rx_valid_out; endproperty
  a_init: assert property (p_init) else $error("init not held");
  property p_cs; cs_n_in [*2] |=> !rd_req_out; endproperty
  a_cs: assert property (p_cs) else $error("read unselected");
  property p_rd3; p3 && $fell(e_rd_n_in) |-> ##[1:3] rd_req_out; endproperty
  a_rd3: assert property (p_rd3) else $error("no split read");
  property p_rd1; p1 && rw_wr_n_in && $rose(e_rd_n_in) |-> ##[1:3] rd_req_out; endproperty
  a_rd1: assert property (p_rd1) else $error("no enable read");
  property p_nord; (mode_out == 2'h1 && !rw_wr_n_in) [*4] |-> !rd_req_out; endproperty
  a_nord: assert property (p_nord) else $error("read on write");
  property p_pulse; rd_req_out |=> !rd_req_out; endproperty
  a_pulse: assert property (p_pulse) else $error("read pulse long");
  property p_wr; p3 && $rose(rw_wr_n_in) && !rx_valid_out |-> ##[2:4] rx_valid_out; endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  c_rd: cover property (rd_req_out);
  c_wr: cover property (rx_valid_out && mode_out == 2'h3);
  c_spi: cover property (rx_valid_out && mode_out == 2'h0);
endmodule // dhi_host_if_asserts
bind dhi_host_if dhi_host_if_asserts u_chk (.clock_in, .rst_in, .iface_strap_hi_in, .iface_strap_lo_in,
  .power_on_init_n_in, .cs_n_in, .e_rd_n_in, .rw_wr_n_in, .rx_valid_out, .rd_req_out, .mode_out, .init_busy_out);
`default_nettype wire

/* bench/dhi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dhi_host_model (
  input wire logic clock_in, // Clock
  input wire logic [7:0] bus_in, // Resolved lines
  output logic cs_n_out = 1'h1, // Select
  output logic dc_out = 1'h0, // Data or command
  output logic e_rd_n_out = 1'h1, // Strobe
  output logic rw_wr_n_out = 1'h1, // Strobe
  output logic [7:0] data_out = 8'hFF // Host lines
);
  // Serial modes ground both strobes
  task automatic idle(input logic [1:0] m);
    @(posedge clock_in);
    e_rd_n_out <= m == 2'h3;
    rw_wr_n_out <= m == 2'h3;
  endtask
  // Parallel write, strobe phases of two cycles
  task automatic wr(input logic [1:0] m, input logic c, input logic d, input logic [7:0] b);
    @(posedge clock_in);
    cs_n_out <= c;
    dc_out <= d;
    data_out <= b;
    if (m == 2'h3) rw_wr_n_out <= 1'h0;
    else e_rd_n_out <= 1'h1;
    repeat (2) @(posedge clock_in);
    if (m == 2'h3) rw_wr_n_out <= 1'h1;
    else e_rd_n_out <= 1'h0;
    repeat (2) @(posedge clock_in);
    cs_n_out <= 1'h1;
    data_out <= ~b; // Released lines flip
    repeat (2) @(posedge clock_in);
  endtask
  // Parallel read, lines sampled late in the strobe
  task automatic rd(input logic [1:0] m, output logic [7:0] b);
    @(posedge clock_in);
    cs_n_out <= 1'h0;
    rw_wr_n_out <= 1'h1;
    e_rd_n_out <= m != 2'h3;
    repeat (3) @(posedge clock_in);
    #1 b = bus_in;
    @(posedge clock_in);
    e_rd_n_out <= m == 2'h3;
    repeat (2) @(posedge clock_in);
    cs_n_out <= 1'h1;
    rw_wr_n_out <= m == 2'h3;
    repeat (2) @(posedge clock_in);
  endtask
  // Two-wire frame of three bytes, ninth clock samples acknowledge
  task automatic i2c(input logic [23:0] w, output logic [2:0] a);
    logic [23:0] s;
    @(posedge clock_in);
    s = w;
    data_out[1:0] <= 2'h3;
    repeat (2) @(posedge clock_in);
    data_out[1] <= 1'h0;
    repeat (2) @(posedge clock_in);
    for (int j = 2; j >= 0; j--) begin
      for (int i = 0; i < 8; i++) begin
        data_out[0] <= 1'h0;
        data_out[1] <= s[23];
        s = s << 1;
        repeat (2) @(posedge clock_in);
        data_out[0] <= 1'h1;
        repeat (2) @(posedge clock_in);
      end
      data_out[0] <= 1'h0;
      data_out[1] <= 1'h1;
      repeat (2) @(posedge clock_in);
      data_out[0] <= 1'h1;
      @(posedge clock_in);
      #1 a[j] = bus_in[1];
      @(posedge clock_in);
    end
    data_out[0] <= 1'h0;
    data_out[1] <= 1'h0;
    repeat (2) @(posedge clock_in);
    data_out[0] <= 1'h1;
    repeat (2) @(posedge clock_in);
    data_out[1] <= 1'h1;
    repeat (2) @(posedge clock_in);
  endtask
  // Four-wire byte, MSB first, clock still outside frames
  task automatic spi(input logic d, input logic [7:0] b);
    @(posedge clock_in);
    cs_n_out <= 1'h0;
    dc_out <= d;
    for (int i = 7; i >= 0; i--) begin
      data_out[1] <= b[i];
      data_out[0] <= 1'h0;
      repeat (2) @(posedge clock_in);
      data_out[0] <= 1'h1;
      repeat (2) @(posedge clock_in);
    end
    data_out[0] <= 1'h0;
    repeat (2) @(posedge clock_in);
    cs_n_out <= 1'h1;
    data_out[1] <= ~b[0];
  endtask
endmodule // dhi_host_model
`default_nettype wire

/* bench/display_host_interface_test.sv */
`timescale 1ns/1ps
`default_nettype none
module display_host_interface_test;
  logic clock_in = 1'h0, rst_in = 1'h1, iface_strap_hi_in = 1'h1, iface_strap_lo_in = 1'h1;
  logic power_on_init_n_in = 1'h1, rx_ready_in = 1'h0, cs_n_in, dc_in, e_rd_n_in, rw_wr_n_in;
  logic [7:0] rd_byte_in = 8'h5A, hd, host_data_bus_in, host_data_bus_out, rx_byte_out, r;
  logic host_data_bus_oe_out, rx_is_data_out, rx_valid_out, rd_req_out, init_busy_out;
  logic [1:0] mode_out;
  logic [2:0] ack;
  logic sda;
  int n_mismatch = 0, n_checks = 0;
  // Clock and resolved data lines
  always #12.5 clock_in = ~clock_in;
  assign sda = hd[1] & ~(host_data_bus_oe_out & ~host_data_bus_out[2]);
  assign host_data_bus_in = mode_out == 2'h2 ? {hd[7:3], sda, sda, hd[0]} :
    host_data_bus_oe_out ? host_data_bus_out : hd;
  dhi_host_model host (.clock_in(clock_in), .bus_in(host_data_bus_in), .cs_n_out(cs_n_in), .dc_out(dc_in),
    .e_rd_n_out(e_rd_n_in), .rw_wr_n_out(rw_wr_n_in), .data_out(hd));
  dhi_host_if dut (.clock_in, .rst_in, .iface_strap_hi_in, .iface_strap_lo_in, .power_on_init_n_in, .cs_n_in,
    .dc_in, .e_rd_n_in, .rw_wr_n_in, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_out, .rd_byte_in,
    .rx_byte_out, .rx_is_data_out, .rx_valid_out, .rx_ready_in, .rd_req_out, .mode_out, .init_busy_out);
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Wait for a received byte, compare it, then accept it
  task automatic pop(input logic [7:0] b, input logic d);
    int i;
    for (i = 0; i < 40 && rx_valid_out !== 1'h1; i++) @(posedge clock_in) #1;
    if (i == 40) begin
      n_mismatch++;
      conclude;
    end
    check("rx_byte", b, rx_byte_out);
    check("rx_is_data", {7'h0, d}, {7'h0, rx_is_data_out});
    @(posedge clock_in) rx_ready_in <= 1'h1;
    @(posedge clock_in) rx_ready_in <= 1'h0;
    #1;
  endtask
  // New straps, then an init pulse that flushes pending bytes
  task automatic setmode(input logic [1:0] m);
    host.idle(m);
    {iface_strap_hi_in, iface_strap_lo_in} <= m;
    power_on_init_n_in <= 1'h0;
    repeat (4) @(posedge clock_in) #1;
    check("init_busy", 8'h01, {7'h0, init_busy_out});
    check("rx_valid", 8'h00, {7'h0, rx_valid_out});
    @(posedge clock_in) power_on_init_n_in <= 1'h1;
    repeat (4) @(posedge clock_in) #1;
    check("mode", {6'h0, m}, {6'h0, mode_out});
    check("init_busy", 8'h00, {7'h0, init_busy_out});
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'h0;
    repeat (2) @(posedge clock_in);
    setmode(2'h3);
    host.wr(2'h3, 1'h0, 1'h1, 8'hA5);
    host.wr(2'h3, 1'h0, 1'h0, 8'h3C);
    pop(8'hA5, 1'h1);
    pop(8'h3C, 1'h0);
    host.wr(2'h3, 1'h1, 1'h1, 8'h77);
    repeat (8) @(posedge clock_in) #1;
    check("rx_valid", 8'h00, {7'h0, rx_valid_out});
    host.rd(2'h3, r);
    check("read", 8'h5A, r);
    // Fill past depth with the core stalled, then drain in order
    for (int k = 0; k < 10; k++) host.wr(2'h3, 1'h0, k[0], 8'h10 + k[7:0]);
    for (int k = 0; k < 8; k++) pop(8'h10 + k[7:0], k[0]);
    repeat (4) @(posedge clock_in) #1;
    check("after_full", 8'h00, {7'h0, rx_valid_out});
    host.wr(2'h3, 1'h0, 1'h1, 8'hEE);
    @(posedge clock_in) rd_byte_in <= 8'hC6;
    setmode(2'h1);
    host.wr(2'h1, 1'h0, 1'h0, 8'h81);
    pop(8'h81, 1'h0);
    host.rd(2'h1, r);
    check("read", 8'hC6, r);
    setmode(2'h0);
    host.spi(1'h1, 8'hC3);
    pop(8'hC3, 1'h1);
    host.spi(1'h0, 8'h2D);
    pop(8'h2D, 1'h0);
    setmode(2'h2);
    host.i2c(24'h7840C3, ack);
    check("ack", 8'h00, {5'h0, ack});
    pop(8'hC3, 1'h1);
    host.i2c(24'h7A40C3, ack);
    check("nack", 8'h07, {5'h0, ack});
    conclude;
  end
endmodule // display_host_interface_test
`default_nettype wire
